/* imac_top.sv */
// I2C mode and address configuration: registers, target-address match and command screening
`timescale 1ns/1ps
`default_nettype none

module imac_top
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Link pins, sampled
   input wire logic scl_in,
   input wire logic sda_in,
   // Command screening from the transmit queue
   input wire logic cmd_valid,
   input wire logic cmd_is_read,
   input wire logic tx_fifo_pending,
   // Configuration outputs
   output logic [1:0] rate_sel,
   output logic ctrl_en,
   output logic target_active,
   output logic [9:0] tx_addr,
   output logic [1:0] special_mode,
   output logic [3:0] spike_len,
   output logic cmd_accept,
   output logic addr_match,
   output logic tx_abort_flag
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic scl_s;
   logic sda_s;

   imac_sync u_scl_sync
   (
      .clk(clk),
      .srst(srst),
      .pin_in(scl_in),
      .pin_out(scl_s)
   );

   imac_sync u_sda_sync
   (
      .clk(clk),
      .srst(srst),
      .pin_in(sda_in),
      .pin_out(sda_s)
   );

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   imac_pkg::imac_cfg_t cfg_r;
   imac_pkg::imac_cfg_t cfg_nxt;
   imac_pkg::imac_remote_t remote_r;
   imac_pkg::imac_remote_t remote_nxt;
   logic [9:0] own_addr_r;
   logic [9:0] own_addr_nxt;
   logic block_on_reg_r;
   logic block_on_reg_nxt;
   logic abort_r;
   logic abort_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] wr_rate;
   logic abort_event;

   always_comb
   begin
      cfg_nxt = cfg_r;
      remote_nxt = remote_r;
      own_addr_nxt = own_addr_r;
      block_on_reg_nxt = block_on_reg_r;
      abort_nxt = abort_r;
      wr_rate = reg_wdata[imac_pkg::CTL_RATE_LO +: 2];
      if (reg_wr)
      begin
         case (reg_addr)
            imac_pkg::OFS_CONTROL:
            begin
               cfg_nxt.ctrl_en = reg_wdata[imac_pkg::CTL_CTRL_EN_BIT];
               cfg_nxt.target_wide_addr_sel = reg_wdata[imac_pkg::CTL_WIDE_BIT];
               cfg_nxt.target_role_off = reg_wdata[imac_pkg::CTL_TGT_OFF_BIT];
               // Hardware guards the rate field against illegal codes
               if (wr_rate == 2'h0 || wr_rate > imac_pkg::TOP_RATE_LIMIT)
               begin
                  cfg_nxt.rate = imac_pkg::TOP_RATE_LIMIT;
               end
               else
               begin
                  cfg_nxt.rate = wr_rate;
               end
            end
            imac_pkg::OFS_REMOTE:
            begin
               if (!block_on_reg_r)
               begin
                  // Writes while enabled are dropped
                  remote_nxt = reg_wdata[11:0];
               end
            end
            imac_pkg::OFS_OWN:
            begin
               if (!block_on_reg_r)
               begin
                  own_addr_nxt = reg_wdata[9:0];
               end
            end
            imac_pkg::OFS_BLOCK_ON:
            begin
               block_on_reg_nxt = reg_wdata[0];
            end
            imac_pkg::OFS_RAW_EVENT:
            begin
               // Writing one to the abort bit clears it
               if (reg_wdata[imac_pkg::RAW_ABORT_BIT])
               begin
                  abort_nxt = 1'h0;
               end
            end
            default:
            begin
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      if (abort_event)
      begin
         abort_nxt = 1'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   always_comb
   begin
      rdata_nxt = 32'h00000000;
      if (reg_rd)
      begin
         case (reg_addr)
            imac_pkg::OFS_CONTROL:
            begin
               rdata_nxt[imac_pkg::CTL_CTRL_EN_BIT] = cfg_r.ctrl_en;
               rdata_nxt[imac_pkg::CTL_RATE_LO +: 2] = cfg_r.rate;
               rdata_nxt[imac_pkg::CTL_WIDE_BIT] = cfg_r.target_wide_addr_sel;
               rdata_nxt[imac_pkg::CTL_TGT_OFF_BIT] = cfg_r.target_role_off;
            end
            imac_pkg::OFS_REMOTE:
            begin
               rdata_nxt[11:0] = remote_r;
            end
            imac_pkg::OFS_OWN:
            begin
               rdata_nxt[9:0] = own_addr_r;
            end
            imac_pkg::OFS_BLOCK_ON:
            begin
               rdata_nxt[0] = block_on_reg_r;
            end
            imac_pkg::OFS_RAW_EVENT:
            begin
               rdata_nxt[imac_pkg::RAW_ABORT_BIT] = abort_r;
            end
            imac_pkg::OFS_STATE:
            begin
               rdata_nxt[imac_pkg::STATE_TFNE_BIT] = ~tx_fifo_pending;
            end
            default:
            begin
               rdata_nxt = 32'h00000000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Special command decode and command screening
   // ----------------------------------------------------------------------
   imac_pkg::imac_special_t special_now;
   logic accept_nxt;
   logic [9:0] tx_addr_nxt;
   logic [1:0] special_nxt;

   always_comb
   begin
      special_now = imac_pkg::IMAC_NORMAL;
      // Bit 10 matters only with bit 11 set
      if (remote_r.special)
      begin
         // Stays general call until bit 11 is cleared
         if (remote_r.broadcast_or_startbyte_sel)
         begin
            special_now = imac_pkg::IMAC_STARTBYTE;
         end
         else
         begin
            special_now = imac_pkg::IMAC_GENCALL;
         end
      end
      special_nxt = special_now;
      tx_addr_nxt = remote_r.addr;
      if (special_now == imac_pkg::IMAC_GENCALL)
      begin
         tx_addr_nxt = {3'h0, imac_pkg::GEN_CALL_ADDR};
      end
      accept_nxt = 1'h0;
      abort_event = 1'h0;
      if (cmd_valid && block_on_reg_r && cfg_r.ctrl_en)
      begin
         if (special_now == imac_pkg::IMAC_GENCALL && cmd_is_read)
         begin
            abort_event = 1'h1;
         end
         else if (!cfg_r.target_role_off && tx_addr_nxt == own_addr_r && special_now == imac_pkg::IMAC_NORMAL)
         begin
            // Shared queues: no controller-to-own-target duplex transfer
            abort_event = 1'h1;
         end
         else
         begin
            accept_nxt = 1'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Target address match on the synchronised link
   // ----------------------------------------------------------------------
   // Address bits shift in on rising SCL; byte boundaries framed by START.
   logic scl_d_r;
   logic sda_d_r;
   logic [3:0] bit_cnt_r;
   logic [3:0] bit_cnt_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [7:0] first_byte_r;
   logic [7:0] first_byte_nxt;
   logic byte_idx_r;
   logic byte_idx_nxt;
   logic match_r;
   logic match_nxt;
   logic [7:0] shifted;

   always_comb
   begin
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      first_byte_nxt = first_byte_r;
      byte_idx_nxt = byte_idx_r;
      match_nxt = match_r;
      shifted = {shift_r[6:0], sda_s};
      if (scl_s && sda_d_r && !sda_s)
      begin
         // START or repeated START
         bit_cnt_nxt = 4'h0;
         byte_idx_nxt = 1'h0;
         match_nxt = 1'h0;
      end
      else if (scl_s && !sda_d_r && sda_s)
      begin
         match_nxt = 1'h0;
      end
      else if (scl_s && !scl_d_r)
      begin
         if (bit_cnt_r == 4'h8)
         begin
            bit_cnt_nxt = 4'h0;
         end
         else
         begin
            shift_nxt = shifted;
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h7 && !cfg_r.target_role_off && block_on_reg_r)
            begin
               byte_idx_nxt = 1'h1;
               if (!byte_idx_r)
               begin
                  first_byte_nxt = shifted;
                  if (cfg_r.target_wide_addr_sel)
                  begin
                     match_nxt = 1'h0;
                  end
                  else if (shifted[7:3] != imac_pkg::WIDE_PREFIX[6:2])
                  begin
                     match_nxt = (shifted[7:1] == own_addr_r[6:0]);
                  end
               end
               else if (cfg_r.target_wide_addr_sel && first_byte_r[7:3] == imac_pkg::WIDE_PREFIX[6:2])
               begin
                  match_nxt = ({first_byte_r[2:1], shifted} == own_addr_r);
               end
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cfg_r <= '{target_role_off: 1'h1, target_wide_addr_sel: 1'h0,
                    rate: imac_pkg::RATE_RST, ctrl_en: 1'h1};
         remote_r <= '{special: 1'h0, broadcast_or_startbyte_sel: 1'h0, addr: imac_pkg::ADDR_RST};
         own_addr_r <= imac_pkg::ADDR_RST;
         block_on_reg_r <= 1'h0;
         abort_r <= 1'h0;
         rdata_r <= 32'h00000000;
         scl_d_r <= 1'h1;
         sda_d_r <= 1'h1;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         first_byte_r <= 8'h00;
         byte_idx_r <= 1'h0;
         match_r <= 1'h0;
         rate_sel <= imac_pkg::RATE_RST;
         ctrl_en <= 1'h1;
         target_active <= 1'h0;
         tx_addr <= imac_pkg::ADDR_RST;
         special_mode <= 2'h0;
         spike_len <= 4'h0;
         cmd_accept <= 1'h0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         remote_r <= remote_nxt;
         own_addr_r <= own_addr_nxt;
         block_on_reg_r <= block_on_reg_nxt;
         abort_r <= abort_nxt;
         rdata_r <= rdata_nxt;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         first_byte_r <= first_byte_nxt;
         byte_idx_r <= byte_idx_nxt;
         match_r <= match_nxt;
         rate_sel <= cfg_r.rate;
         ctrl_en <= cfg_r.ctrl_en;
         target_active <= block_on_reg_r & ~cfg_r.target_role_off;
         tx_addr <= tx_addr_nxt;
         special_mode <= special_nxt;
         // Spike window follows the rate even in target-only use
         spike_len <= (cfg_r.rate == imac_pkg::RATE_HIGH) ? 4'(imac_pkg::SPIKE_HIGH_CYC)
                                                           : 4'(imac_pkg::SPIKE_STD_CYC);
         cmd_accept <= accept_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign addr_match = match_r;
   assign tx_abort_flag = abort_r;

endmodule

`default_nettype wire

/* imac_pkg.sv */
// Package: constants, register map and carrier types for the I2C mode and address configuration block
//
// Notes on behaviour
// - Rate field value 1 standard, 2 fast/fast-plus, 3 high-speed.
// - Rate write outside one..maximum is replaced by the maximum rate value.
// - Rate field resets to two.
// - Control bit 0 enables controller role; resets to one.
// - Target-address register written only while block is disabled.
// - Target bit 11 enables special command chosen by bit 10.
// - Bit 10 clear is general call, set is start byte; both reset zero.
// - After general call a queued read aborts and sets raw abort bit 6.
// - General-call operation persists until software clears bit 11.
// - Ten-bit target address used for transactions, ignored for general call, resets 0x055.
// - Equal target and own addresses: controller may not address itself.
// - Target-address register is 12 bits; bits 31 to 12 read zero.
// - Own address ten bits, resets 0x055; seven-bit match uses low seven bits.
// - Own-address writes while enabled are discarded.
// - Target-disable bit 6 set means no target-role action.
// - Seven-bit target mode ignores ten-bit transfers; ten-bit mode matches all bits.

`default_nettype none

package imac_pkg;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_REMOTE = 8'h04;
   localparam logic [7:0] OFS_OWN = 8'h08;
   localparam logic [7:0] OFS_BLOCK_ON = 8'h6C;
   localparam logic [7:0] OFS_RAW_EVENT = 8'h34;
   localparam logic [7:0] OFS_STATE = 8'h70;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CTL_CTRL_EN_BIT = 0;
   localparam int CTL_RATE_LO = 1;
   localparam int CTL_WIDE_BIT = 3;
   localparam int CTL_TGT_OFF_BIT = 6;
   localparam int TAR_SEL_BIT = 10;
   localparam int TAR_SPECIAL_BIT = 11;
   localparam int RAW_ABORT_BIT = 6;
   localparam int STATE_TFNE_BIT = 2;

   // ----------------------------------------------------------------------
   // Rate codes, reset values and fixed address patterns
   // ----------------------------------------------------------------------
   localparam logic [1:0] RATE_STD = 2'h1;
   localparam logic [1:0] RATE_FAST = 2'h2;
   localparam logic [1:0] RATE_HIGH = 2'h3;
   localparam logic [1:0] RATE_RST = 2'h2;
   localparam logic [1:0] TOP_RATE_LIMIT = 2'h3;
   localparam logic [9:0] ADDR_RST = 10'h055;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [6:0] WIDE_PREFIX = 7'h78;

   // Spike windows in ns, rounded up to whole clock cycles
   localparam int SPIKE_STD_NS = 50;
   localparam int SPIKE_HIGH_NS = 10;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SPIKE_STD_CYC = (SPIKE_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SPIKE_HIGH_CYC = (SPIKE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {IMAC_NORMAL, IMAC_GENCALL, IMAC_STARTBYTE} imac_special_t;

   typedef struct packed {
      logic target_role_off;
      logic target_wide_addr_sel;
      logic [1:0] rate;
      logic ctrl_en;
   } imac_cfg_t;

   typedef struct packed {
      logic special;
      logic broadcast_or_startbyte_sel;
      logic [9:0] addr;
   } imac_remote_t;

endpackage

`default_nettype wire

/* imac_sync.sv */
// Three-stage synchroniser with agreement filter for one link pin
`timescale 1ns/1ps
`default_nettype none

module imac_sync
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Pin
   input wire logic pin_in,
   output logic pin_out
);

   logic [2:0] stage_r;
   logic [2:0] stage_nxt;
   logic level_r;
   logic level_nxt;

   always_comb
   begin
      stage_nxt = {stage_r[1:0], pin_in};
      level_nxt = level_r;
      // First stage is read only by the second
      if (stage_r[1] == stage_r[2])
      begin
         level_nxt = stage_r[2];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stage_r <= 3'h7;
         level_r <= 1'h1;
      end
      else
      begin
         stage_r <= stage_nxt;
         level_r <= level_nxt;
      end
   end

   assign pin_out = level_r;

endmodule

`default_nettype wire

/* imac_top_props.sv */
// Concurrent checks on the ports of the mode and address configuration block
`timescale 1ns/1ps
`default_nettype none

module imac_top_props
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_rdata,
   // Commands
   input wire logic cmd_valid,
   input wire logic cmd_is_read,
   input wire logic cmd_accept,
   input wire logic tx_abort_flag,
   // Configuration and link
   input wire logic [1:0] rate_sel,
   input wire logic [3:0] spike_len,
   input wire logic [1:0] special_mode,
   input wire logic [9:0] tx_addr,
   input wire logic target_active,
   input wire logic ctrl_en,
   input wire logic addr_match
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   chk_rate_legal: assert property (rate_sel != 2'h0)
      else $error("rate field holds zero");
   // Three steady cycles cover the lag of derived outputs behind the field
   chk_spike_high: assert property ((rate_sel == 2'h3) [*3] |-> spike_len == 4'h2)
      else $error("spike window wrong for high rate");
   chk_spike_low: assert property ((rate_sel != 2'h3) [*3] |-> spike_len == 4'h7)
      else $error("spike window wrong for low rates");
   chk_accept_cause: assert property (cmd_accept |-> $past(cmd_valid)
      && !($past(cmd_is_read) && $past(special_mode) == 2'h1))
      else $error("command accepted without a legal cause");
   chk_gc_read_abort: assert property (cmd_valid && cmd_is_read && special_mode == 2'h1
      && ctrl_en && target_active |=> tx_abort_flag)
      else $error("broadcast read not aborted");
   chk_abort_sticky: assert property ($past(tx_abort_flag) && !$past(reg_wr) |-> tx_abort_flag)
      else $error("abort flag dropped without a write");
   chk_abort_cause: assert property ($rose(tx_abort_flag) |-> $past(cmd_valid))
      else $error("abort flag set without a command");
   chk_gc_addr: assert property (special_mode == 2'h1 |-> tx_addr == 10'h000)
      else $error("address not ignored in broadcast mode");
   chk_mode_code: assert property (special_mode != 2'h3)
      else $error("undefined special mode");
   chk_match_gate: assert property ($rose(addr_match) |-> target_active)
      else $error("match while target role is off");
endmodule

bind imac_top imac_top_props chk (.clk(clk), .srst(srst), .reg_rd(reg_rd), .reg_wr(reg_wr),
   .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_is_read(cmd_is_read), .cmd_accept(cmd_accept),
   .tx_abort_flag(tx_abort_flag), .rate_sel(rate_sel), .spike_len(spike_len),
   .special_mode(special_mode), .tx_addr(tx_addr), .target_active(target_active), .ctrl_en(ctrl_en),
   .addr_match(addr_match));
`default_nettype wire

/* imac_link_model.sv */
// Behavioural controller on the two-wire link
`timescale 1ns/1ps
`default_nettype none

module imac_link_model
(
   // Link lines, pulled up when released
   output var logic scl,
   output var logic sda
);
   // ----------
   // Frames
   // ----------
   // Clock stands still between frames; odd offset keeps it off the block clock phase when a frame starts on a rising clock edge
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic start_cond();
      #3 sda = 1'b0;
      #40 scl = 1'b0;
   endtask

   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         #20 sda = b[i];
         #20 scl = 1'b1;
         #40 scl = 1'b0;
      end
      // Acknowledge slot: line released to the pull-up
      #20 sda = 1'b1;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
   endtask

   task automatic stop_cond();
      #20 sda = 1'b0;
      #20 scl = 1'b1;
      #40 sda = 1'b1;
   endtask
endmodule
`default_nettype wire

/* imac_top_tb.sv */
// Self-checking bench for the mode and address configuration block
`timescale 1ns/1ps
`default_nettype none

module imac_top_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_is_read = 1'b0;
   logic tx_fifo_pending = 1'b0;
   logic [31:0] reg_rdata;
   logic scl;
   logic sda;
   logic [1:0] rate_sel;
   logic [1:0] special_mode;
   logic [9:0] tx_addr;
   logic [3:0] spike_len;
   logic ctrl_en, target_active, cmd_accept, addr_match, tx_abort_flag;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   imac_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda), .cmd_valid(cmd_valid),
      .cmd_is_read(cmd_is_read), .tx_fifo_pending(tx_fifo_pending), .rate_sel(rate_sel),
      .ctrl_en(ctrl_en), .target_active(target_active), .tx_addr(tx_addr), .special_mode(special_mode),
      .spike_len(spike_len), .cmd_accept(cmd_accept), .addr_match(addr_match),
      .tx_abort_flag(tx_abort_flag));
   imac_link_model link (.scl(scl), .sda(sda));

   // ----------
   // Helpers
   // ----------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check("reg_rdata", exp, reg_rdata);
   endtask

   task automatic blk(input logic on);
      wr(imac_pkg::OFS_BLOCK_ON, 32'(on));
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic cmd(input logic is_rd, input logic acc, input logic abt);
      wr(imac_pkg::OFS_RAW_EVENT, 32'h40);
      repeat (2) @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_is_read <= is_rd;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1 check("cmd_accept", 32'(acc), 32'(cmd_accept));
      check("tx_abort_flag", 32'(abt), 32'(tx_abort_flag));
   endtask

   task automatic frame(input logic [15:0] bytes, input int n, input logic exp);
      link.start_cond();
      for (int i = n - 1; i >= 0; i--)
         link.put_byte(bytes[i*8 +: 8]);
      repeat (8) @(posedge clk);
      #1 check("addr_match", 32'(exp), 32'(addr_match));
      link.stop_cond();
      repeat (8) @(posedge clk);
      #1 check("addr_match", 32'h0, 32'(addr_match));
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic t_reset();
      rd(imac_pkg::OFS_CONTROL, 32'h45);
      rd(imac_pkg::OFS_REMOTE, 32'h55);
      rd(imac_pkg::OFS_OWN, 32'h55);
      rd(8'hFC, 32'h0);
      check("tx_addr", 32'h55, 32'(tx_addr));
      check("ctrl_en", 32'h1, 32'(ctrl_en));
      @(posedge clk);
      tx_fifo_pending <= 1'b1;
      rd(imac_pkg::OFS_STATE, 32'h0);
      @(posedge clk);
      tx_fifo_pending <= 1'b0;
      rd(imac_pkg::OFS_STATE, 32'h4);
   endtask

   task automatic t_rate();
      logic [1:0] exp [4] = '{2'h3, 2'h1, 2'h2, 2'h3};
      for (int r = 0; r < 4; r++)
      begin
         wr(imac_pkg::OFS_CONTROL, 32'h41 | 32'(r << 1));
         blk(1'b0);
         check("rate_sel", 32'(exp[r]), 32'(rate_sel));
         check("spike_len", (exp[r] == 2'h3) ? 32'h2 : 32'h7, 32'(spike_len));
         rd(imac_pkg::OFS_CONTROL, 32'h41 | 32'(exp[r]) << 1);
      end
   endtask

   task automatic t_remote();
      wr(imac_pkg::OFS_REMOTE, 32'hFFFF_FFAA);
      rd(imac_pkg::OFS_REMOTE, 32'hFAA);
      blk(1'b0);
      check("special_mode", 32'h2, 32'(special_mode));
      check("tx_addr", 32'h3AA, 32'(tx_addr));
      wr(imac_pkg::OFS_REMOTE, 32'h800);
      blk(1'b0);
      check("special_mode", 32'h1, 32'(special_mode));
      check("tx_addr", 32'h0, 32'(tx_addr));
      wr(imac_pkg::OFS_REMOTE, 32'h4AB);
      blk(1'b0);
      check("special_mode", 32'h0, 32'(special_mode));
      check("tx_addr", 32'hAB, 32'(tx_addr));
      blk(1'b1);
      wr(imac_pkg::OFS_REMOTE, 32'h123);
      wr(imac_pkg::OFS_OWN, 32'h321);
      rd(imac_pkg::OFS_REMOTE, 32'h4AB);
      rd(imac_pkg::OFS_OWN, 32'h55);
      blk(1'b0);
   endtask

   task automatic t_cmds();
      // Target role left on beside the controller so that self-addressing is reachable
      wr(imac_pkg::OFS_CONTROL, 32'h05);
      wr(imac_pkg::OFS_REMOTE, 32'h800);
      blk(1'b1);
      cmd(1'b1, 1'b0, 1'b1);
      rd(imac_pkg::OFS_RAW_EVENT, 32'h40);
      cmd(1'b0, 1'b1, 1'b0);
      cmd(1'b1, 1'b0, 1'b1);
      blk(1'b0);
      wr(imac_pkg::OFS_REMOTE, 32'h055);
      blk(1'b1);
      cmd(1'b0, 1'b0, 1'b1);
      blk(1'b0);
      wr(imac_pkg::OFS_REMOTE, 32'h0AB);
      blk(1'b1);
      cmd(1'b1, 1'b1, 1'b0);
      wr(imac_pkg::OFS_CONTROL, 32'h44);
      cmd(1'b0, 1'b0, 1'b0);
      check("ctrl_en", 32'h0, 32'(ctrl_en));
   endtask

   task automatic t_link();
      // Target role only: rate still programmed, remote address left alone
      wr(imac_pkg::OFS_CONTROL, 32'h04);
      frame(16'h00AA, 1, 1'b1);
      check("target_active", 32'h1, 32'(target_active));
      frame(16'h00AC, 1, 1'b0);
      frame(16'hF455, 2, 1'b0);
      blk(1'b0);
      wr(imac_pkg::OFS_OWN, 32'h2D5);
      blk(1'b1);
      frame(16'h00AA, 1, 1'b1);
      wr(imac_pkg::OFS_CONTROL, 32'h0C);
      frame(16'hF4D5, 2, 1'b1);
      frame(16'hF4D4, 2, 1'b0);
      wr(imac_pkg::OFS_CONTROL, 32'h4D);
      frame(16'hF4D5, 2, 1'b0);
      check("target_active", 32'h0, 32'(target_active));
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_rate();
      t_remote();
      t_cmds();
      t_link();
      wrap_up();
   end

   // Whole run needs under two thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end
endmodule
`default_nettype wire
